// ==== common/rgc_pkg.sv ====
// constants and carriers for the reset and general configuration registers
// What this block does
// - software reset honoured only at 3.3V signalling
// - bit 4 resets video input logic, self-clears
// - bit 1 resets whole core, self-clears
// - bit 0 resets core keeping registers, self-clears
// - core-only reset reloads strap-loaded register values
// - core-only reset restores listed registers to defaults
// - config bit 7 enables crc checker, reset 0xd2
// - config bit 5 auto-acknowledges remote writes
// - auto-acknowledge hides remote not-acknowledge
// - second port select retargets ack and pass-through
// - config bit 4 filters sub-two-clock sync pulses
// - config bit 3 forwards alias-matched transactions
package rgc_pkg;
  localparam logic [7:0] RESET_CTRL_ADDR = 8'h01;
  localparam logic [7:0] GEN_CFG_ADDR = 8'h03;
  localparam logic [7:0] RESET_CTRL_RST = 8'h00;
  localparam logic [7:0] GEN_CFG_RST = 8'hd2;
  localparam logic [7:0] GEN_CFG_WMASK = 8'hb8;
  localparam int RST_VIDEO_BIT = 4;
  localparam int RST_FULL_BIT = 1;
  localparam int RST_LOGIC_BIT = 0;
  localparam int CFG_CRC_BIT = 7;
  localparam int CFG_AUTOACK_BIT = 5;
  localparam int CFG_FILTER_BIT = 4;
  localparam int CFG_PASS_BIT = 3;
  // reset counter load value; the reset pulse lasts this many clocks plus one
  localparam logic [3:0] RESET_PULSE_CYCLES = 4'h4;
  // control outputs grouped for both ports
  typedef struct packed {
    logic crc_check_en;
    logic autoack_p0;
    logic autoack_p1;
    logic pass_p0;
    logic pass_p1;
    logic sync_filter_en;
  } rgc_cfg_type;
endpackage

// ==== src/rgc_regs.sv ====
// reset register and general configuration register with reset sequencing
`timescale 1ns/1ps
module rgc_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register write and read port from the serial control slave
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_q,
  // control bus signalling at 3.3v, from a pin
  input wire logic io_3v3,
  input wire logic second_port_select,
  // remote acknowledge handling
  input wire logic remote_write,
  input wire logic remote_nack,
  output logic local_nack_q,
  // resets to the core
  output logic video_reset_q,
  output logic core_reset_q,
  output logic logic_only_reset_q,
  output logic strap_reload_q,
  output logic listed_regs_restore_q,
  // configuration outputs
  output rgc_pkg::rgc_cfg_type cfg_q
);
  logic v33_s1_q, v33_q;
  logic [7:0] gen_cfg_q;
  logic [2:0] busy_q;
  logic [3:0] cnt_v_q, cnt_f_q, cnt_l_q;

  // two-flop sync of the level pin
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      v33_s1_q <= 1'b0;
      v33_q <= 1'b0;
    end else begin
      v33_s1_q <= io_3v3;
      v33_q <= v33_s1_q;
    end
  end

  logic wr_rst;
  assign wr_rst = wr_en && addr == rgc_pkg::RESET_CTRL_ADDR && v33_q;

  // one decode shared by the counters, the outputs and the checks
  function automatic logic rst_hit(input logic hit, input logic [7:0] d, input int b);
    return hit && d[b];
  endfunction

  logic start_v, start_f, start_l;
  assign start_v = rst_hit(wr_rst, wdata, rgc_pkg::RST_VIDEO_BIT);
  assign start_f = rst_hit(wr_rst, wdata, rgc_pkg::RST_FULL_BIT);
  assign start_l = rst_hit(wr_rst, wdata, rgc_pkg::RST_LOGIC_BIT);

  // each reset bit starts a fixed-length pulse then clears itself
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_v_q <= 4'h0;
      cnt_f_q <= 4'h0;
      cnt_l_q <= 4'h0;
    end else begin
      if (start_v) begin
        cnt_v_q <= rgc_pkg::RESET_PULSE_CYCLES;
      end else if (cnt_v_q != 4'h0) begin
        cnt_v_q <= cnt_v_q - 4'h1;
      end
      if (start_f) begin
        cnt_f_q <= rgc_pkg::RESET_PULSE_CYCLES;
      end else if (cnt_f_q != 4'h0) begin
        cnt_f_q <= cnt_f_q - 4'h1;
      end
      if (start_l) begin
        cnt_l_q <= rgc_pkg::RESET_PULSE_CYCLES;
      end else if (cnt_l_q != 4'h0) begin
        cnt_l_q <= cnt_l_q - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_q <= 3'h0;
      video_reset_q <= 1'b0;
      core_reset_q <= 1'b0;
      logic_only_reset_q <= 1'b0;
      strap_reload_q <= 1'b0;
      listed_regs_restore_q <= 1'b0;
    end else begin
      // read-back drops no later than the pulse itself, never after it
      busy_q <= {cnt_v_q > 4'h1, cnt_f_q > 4'h1, cnt_l_q > 4'h1};
      video_reset_q <= cnt_v_q != 4'h0 || start_v;
      core_reset_q <= cnt_f_q != 4'h0 || start_f;
      logic_only_reset_q <= cnt_l_q != 4'h0 || start_l;
      // one pulse at start of core-only reset
      strap_reload_q <= start_l;
      listed_regs_restore_q <= start_l;
    end
  end

  // full digital reset also restores this register to its reset value
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gen_cfg_q <= rgc_pkg::GEN_CFG_RST;
    end else if (core_reset_q) begin
      gen_cfg_q <= rgc_pkg::GEN_CFG_RST;
    end else if (wr_en && addr == rgc_pkg::GEN_CFG_ADDR) begin
      // reserved bits keep reset value
      gen_cfg_q <= (wdata & rgc_pkg::GEN_CFG_WMASK) |
                   (rgc_pkg::GEN_CFG_RST & ~rgc_pkg::GEN_CFG_WMASK);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_q <= '0;
      cfg_q.crc_check_en <= 1'b1;
      cfg_q.sync_filter_en <= 1'b1;
    end else begin
      cfg_q.crc_check_en <= gen_cfg_q[rgc_pkg::CFG_CRC_BIT];
      cfg_q.sync_filter_en <= gen_cfg_q[rgc_pkg::CFG_FILTER_BIT];
      cfg_q.autoack_p0 <= gen_cfg_q[rgc_pkg::CFG_AUTOACK_BIT] && !second_port_select;
      cfg_q.autoack_p1 <= gen_cfg_q[rgc_pkg::CFG_AUTOACK_BIT] && second_port_select;
      cfg_q.pass_p0 <= gen_cfg_q[rgc_pkg::CFG_PASS_BIT] && !second_port_select;
      cfg_q.pass_p1 <= gen_cfg_q[rgc_pkg::CFG_PASS_BIT] && second_port_select;
    end
  end

  // remote nack reaches the local master only without auto-acknowledge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      local_nack_q <= 1'b0;
    end else begin
      local_nack_q <= remote_write && remote_nack &&
                      !gen_cfg_q[rgc_pkg::CFG_AUTOACK_BIT];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        rgc_pkg::RESET_CTRL_ADDR: rdata_q <= {3'h0, busy_q[2], 2'h0, busy_q[1], busy_q[0]};
        rgc_pkg::GEN_CFG_ADDR: rdata_q <= gen_cfg_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // remote acknowledge handling
  nack_hidden_a: assert property (@(posedge mclk) disable iff (reset)
    gen_cfg_q[rgc_pkg::CFG_AUTOACK_BIT] |=> !local_nack_q)
    else $error("remote nack passed under auto-ack");
  nack_passed_a: assert property (@(posedge mclk) disable iff (reset)
    remote_write && remote_nack && !gen_cfg_q[rgc_pkg::CFG_AUTOACK_BIT] |=> local_nack_q)
    else $error("remote nack lost without auto-ack");

  // reset pulses: full length, then self-clear unless retriggered
  video_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    start_v |=> video_reset_q [*5])
    else $error("video reset pulse too short");
  video_clear_a: assert property (@(posedge mclk) disable iff (reset)
    start_v ##1 !start_v [*5] |=> !video_reset_q)
    else $error("video reset did not self-clear");
  full_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    start_f |=> core_reset_q [*5])
    else $error("full reset pulse too short");
  full_selfclr_a: assert property (@(posedge mclk) disable iff (reset)
    start_f ##1 !start_f [*5] |=> !core_reset_q)
    else $error("full reset did not self-clear");
  logic_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    start_l |=> logic_only_reset_q [*5])
    else $error("core-only reset pulse too short");
  logic_selfclr_a: assert property (@(posedge mclk) disable iff (reset)
    start_l ##1 !start_l [*5] |=> !logic_only_reset_q)
    else $error("core-only reset did not self-clear");
  no_rst_low_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(core_reset_q) |-> $past(v33_q))
    else $error("reset taken without 3.3v mode");
  level_gate_a: assert property (@(posedge mclk) disable iff (reset)
    wr_en && addr == rgc_pkg::RESET_CTRL_ADDR && !v33_q && cnt_v_q == 4'h0 |=> !video_reset_q)
    else $error("video reset taken without 3.3v mode");
  strap_reload_a: assert property (@(posedge mclk) disable iff (reset)
    strap_reload_q |-> logic_only_reset_q && listed_regs_restore_q)
    else $error("core-only reset reload missing");
  reload_once_a: assert property (@(posedge mclk) disable iff (reset)
    strap_reload_q && !start_l |=> !strap_reload_q)
    else $error("strap reload pulse too long");

  // configuration register and its outputs
  cfg_reserved_a: assert property (@(posedge mclk) disable iff (reset)
    gen_cfg_q[6] && !gen_cfg_q[2] && gen_cfg_q[1] && !gen_cfg_q[0])
    else $error("reserved config bits changed");
  cfg_write_a: assert property (@(posedge mclk) disable iff (reset)
    wr_en && addr == rgc_pkg::GEN_CFG_ADDR && !core_reset_q |=>
      gen_cfg_q[rgc_pkg::CFG_CRC_BIT] == $past(wdata[rgc_pkg::CFG_CRC_BIT]) &&
      gen_cfg_q[rgc_pkg::CFG_AUTOACK_BIT] == $past(wdata[rgc_pkg::CFG_AUTOACK_BIT]) &&
      gen_cfg_q[rgc_pkg::CFG_FILTER_BIT] == $past(wdata[rgc_pkg::CFG_FILTER_BIT]) &&
      gen_cfg_q[rgc_pkg::CFG_PASS_BIT] == $past(wdata[rgc_pkg::CFG_PASS_BIT]))
    else $error("config write not taken");
  crc_follow_a: assert property (@(posedge mclk) disable iff (reset)
    ##1 cfg_q.crc_check_en == $past(gen_cfg_q[rgc_pkg::CFG_CRC_BIT]))
    else $error("crc enable mismatch");
  filter_follow_a: assert property (@(posedge mclk) disable iff (reset)
    ##1 cfg_q.sync_filter_en == $past(gen_cfg_q[rgc_pkg::CFG_FILTER_BIT]))
    else $error("sync filter enable mismatch");
  port_select_a: assert property (@(posedge mclk) disable iff (reset)
    !(cfg_q.autoack_p0 && cfg_q.autoack_p1) && !(cfg_q.pass_p0 && cfg_q.pass_p1))
    else $error("both ports selected");
  port1_route_a: assert property (@(posedge mclk) disable iff (reset)
    ##1 cfg_q.autoack_p1 == ($past(gen_cfg_q[rgc_pkg::CFG_AUTOACK_BIT]) && $past(second_port_select)))
    else $error("auto-ack not routed to second port");
  pass_route_a: assert property (@(posedge mclk) disable iff (reset)
    ##1 cfg_q.pass_p0 == ($past(gen_cfg_q[rgc_pkg::CFG_PASS_BIT]) && !$past(second_port_select)))
    else $error("pass-through not routed to first port");
  full_clear_a: assert property (@(posedge mclk) disable iff (reset)
    core_reset_q |=> gen_cfg_q == rgc_pkg::GEN_CFG_RST)
    else $error("full reset did not restore config");

  // read path
  cfg_read_a: assert property (@(posedge mclk) disable iff (reset)
    rd_en && addr == rgc_pkg::GEN_CFG_ADDR |=> rdata_q == $past(gen_cfg_q))
    else $error("config read-back mismatch");
  rst_read_a: assert property (@(posedge mclk) disable iff (reset)
    rd_en && addr == rgc_pkg::RESET_CTRL_ADDR && !video_reset_q && !core_reset_q &&
      !logic_only_reset_q |=> rdata_q == rgc_pkg::RESET_CTRL_RST)
    else $error("reset bits not clear after reset");
endmodule

// ==== testbench/reset_and_general_config_regs_bench.sv ====
// self-checking bench for the reset and configuration registers
`timescale 1ns/1ps
module reset_and_general_config_regs_bench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic io_3v3 = 1'b0;
  logic second_port_select = 1'b0;
  logic remote_write = 1'b0;
  logic remote_nack = 1'b0;
  logic wr_en, rd_en, local_nack_q, video_reset_q, core_reset_q, logic_only_reset_q;
  logic strap_reload_q, listed_regs_restore_q;
  logic [7:0] addr, wdata, rdata_q, w;
  rgc_pkg::rgc_cfg_type cfg_q;
  int num_errors = 0;
  int n_compared = 0;
  integer seed = 32'h29055d75;
  int cfg_model = 32'hd2;
  always #50 mclk = ~mclk;
  rgc_host i_rgc_host (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata_q(rdata_q));
  rgc_regs i_rgc_regs (.mclk(mclk), .reset(reset), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata_q(rdata_q), .io_3v3(io_3v3),
    .second_port_select(second_port_select), .remote_write(remote_write),
    .remote_nack(remote_nack), .local_nack_q(local_nack_q), .video_reset_q(video_reset_q),
    .core_reset_q(core_reset_q), .logic_only_reset_q(logic_only_reset_q),
    .strap_reload_q(strap_reload_q), .listed_regs_restore_q(listed_regs_restore_q),
    .cfg_q(cfg_q));
  task chk(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (e !== g) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_rgc_host.rd(a, d);
    chk(e, d);
  endtask
  // write, then count pulse cycles of one reset output and the reload pulses
  task wrp(input logic [7:0] a, input logic [7:0] v, input int k, input int e);
    int n;
    int s;
    logic [2:0] rs;
    n = 0;
    s = 0;
    i_rgc_host.wr(a, v);
    repeat (12) begin
      rs = {video_reset_q, core_reset_q, logic_only_reset_q};
      n += (rs[k] === 1'b1);
      s += (strap_reload_q === 1'b1) + (listed_regs_restore_q === 1'b1);
      @(posedge mclk);
      #1;
    end
    chk(e[7:0], n[7:0]);
    if (k == 0) chk((e > 0) ? 8'h02 : 8'h00, s[7:0]);
  endtask
  // model of the config register: bits 7,5,4,3 writable, the rest fixed
  task cfg_wr(input logic [7:0] v);
    i_rgc_host.wr(8'h03, v);
    cfg_model = {24'h0, (v & 8'hb8) | 8'h42};
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge mclk);
    #1 reset = 1'b0;
    rdchk(8'h01, 8'h00);
    rdchk(8'h03, 8'hd2);
    rdchk(8'h07, 8'h00);
    wrp(8'h01, 8'h10, 2, 0);
    io_3v3 = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    wrp(8'h01, 8'h10, 2, 5);
    rdchk(8'h01, 8'h00);
    wrp(8'h01, 8'h01, 0, 5);
    $display("test reset pulses done");
    repeat (8) begin
      w = 8'($random(seed));
      second_port_select = w[0];
      cfg_wr(w);
      repeat (2) @(posedge mclk);
      #1;
      chk({2'h0, w[7], w[4], w[5], w[3], 2'h0}, {2'h0, cfg_q.crc_check_en, cfg_q.sync_filter_en,
        w[0] ? cfg_q.autoack_p1 : cfg_q.autoack_p0,
        w[0] ? cfg_q.pass_p1 : cfg_q.pass_p0,
        w[0] ? cfg_q.autoack_p0 : cfg_q.autoack_p1,
        w[0] ? cfg_q.pass_p0 : cfg_q.pass_p1});
      rdchk(8'h03, cfg_model[7:0]);
    end
    $display("test config fields done");
    second_port_select = 1'b0;
    cfg_wr(8'h00);
    remote_write = 1'b1;
    remote_nack = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(8'h01, {7'h0, local_nack_q});
    cfg_wr(8'h20);
    repeat (3) @(posedge mclk);
    #1;
    chk(8'h00, {7'h0, local_nack_q});
    $display("test nack hiding done");
    wrp(8'h01, 8'h01, 0, 5);
    rdchk(8'h03, cfg_model[7:0]);
    wrp(8'h01, 8'h02, 1, 5);
    cfg_model = 32'hd2;
    rdchk(8'h03, cfg_model[7:0]);
    rdchk(8'h01, 8'h00);
    i_rgc_host.wr(8'h4f, 8'h02);
    rdchk(8'h4f, 8'h00);
    $display("test full reset done");
    close_out();
  end
endmodule

// ==== testbench/rgc_host.sv ====
// host model issuing single-byte register writes and reads
`timescale 1ns/1ps
module rgc_host (
  // clock
  input wire logic mclk,
  // register access
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata_q
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge mclk);
    #1;
    wr_en = 1'b0;
    wdata = ~d;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    rd_en = 1'b1;
    addr = a;
    @(posedge mclk);
    #1;
    rd_en = 1'b0;
    @(posedge mclk);
    #1;
    d = rdata_q;
  endtask
endmodule
